//--- rtl/debug_mode_defs.svh
// Purpose: constants for the single-wire debug mode control block
// Assumes: included by bare name from design files
// Notes:   byte field positions and timing counts in serial ticks
`ifndef DEBUG_MODE_DEFS_SVH
`define DEBUG_MODE_DEFS_SVH

// security field value that marks the part as open
`define SEC_OPEN_CODE       2'h2

// byte select codes for top-byte access
`define BSEL_EXT_CTRL       2'h0
`define BSEL_CTRL_TWO       2'h1
`define BSEL_CTRL_THREE     2'h2

// ext_ctrl_status_reg top byte fields
`define XC_ENABLE_BIT       7
`define XC_CLKSEL_BIT       6

// ctrl_status_two top byte fields
`define C2_FORCE_BIT        7
`define C2_HALT_FORCED_BIT  3
`define C2_HALT_WDOG_BIT    2
`define C2_HALT_OPC_BIT     1
`define C2_HALT_ADDR_BIT    0

// reset values
`define CTRL_TWO_RESET      4'h0
`define CTRL_THREE_RESET    8'h00

// link timing in serial ticks
`define SYNC_REQ_TICKS      8'h10
`define SYNC_RESP_TICKS     8'h10
`define TX_FRAME_BITS       4'hA
`define RX_FRAME_BITS       4'h9

`endif

//--- rtl/debug_mode_pkg.sv
// Purpose: types for the single-wire debug mode control block
// Assumes: nothing
// Notes:   gray coded states along the usual path
package debug_mode_pkg;

    typedef enum logic [1:0] {
        CORE_RUN  = 2'h0,
        CORE_STOP = 2'h1,
        CORE_HALT = 2'h3
    } core_state_t;

    typedef enum logic [1:0] {
        SY_IDLE  = 2'h0,
        SY_LOW   = 2'h1,
        SY_GAP   = 2'h3,
        SY_DRIVE = 2'h2
    } sync_state_t;

    typedef enum logic [3:0] {
        CMD_BYTE_ACCESS = 4'h0,
        CMD_READ_STATUS = 4'h1,
        CMD_MASS_ERASE  = 4'h2,
        CMD_MEM         = 4'h3,
        CMD_MEM_STATUS  = 4'h4,
        CMD_DREG        = 4'h5,
        CMD_ENTER_HALT  = 4'h6,
        CMD_CPU_REG     = 4'h7,
        CMD_STEP        = 4'h8,
        CMD_GO          = 4'h9
    } cmd_class_t;

endpackage : debug_mode_pkg

//--- rtl/sync_responder.sv
// Purpose: answers a long host low on the debug wire with a timed low pulse
// Assumes: tick is the serial clock enable, wire_low already synchronised
// Notes:   pulse starts one tick after the host releases the wire
`timescale 1ns/1ps
`include "debug_mode_defs.svh"
module sync_responder
    import debug_mode_pkg::*;
#(
    parameter logic [7:0] REQ_TICKS  = `SYNC_REQ_TICKS,
    parameter logic [7:0] RESP_TICKS = `SYNC_RESP_TICKS
) (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic tick,
    input  wire logic wire_low,
    output logic      busy,
    output logic      drive
);
    sync_state_t state;
    logic [7:0]  count;

    always_ff @(posedge clk) begin
        if (reset) begin
            state <= SY_IDLE;
            count <= 8'h00;
        end else if (tick) begin
            case (state)
                SY_IDLE: begin
                    if (wire_low) begin
                        state <= SY_LOW;
                        count <= 8'h01;
                    end
                end
                SY_LOW: begin
                    if (wire_low) begin
                        if (count != 8'hFF) count <= count + 8'h01;
                    end else if (count >= REQ_TICKS) begin
                        state <= SY_GAP;
                    end else begin
                        state <= SY_IDLE;
                    end
                end
                SY_GAP: begin
                    state <= SY_DRIVE;
                    count <= 8'h00;
                end
                SY_DRIVE: begin
                    count <= count + 8'h01;
                    if (count == RESP_TICKS - 8'h01) state <= SY_IDLE;
                end
                default: state <= SY_IDLE;
            endcase
        end
    end

    assign busy  = (state == SY_GAP) || (state == SY_DRIVE);
    assign drive = (state == SY_DRIVE);

    a_sync_after_release: assert property (@(posedge clk) disable iff (reset)
        $rose(drive) |-> !wire_low)
        else $error("sync pulse began while host held the wire");

endmodule : sync_responder

//--- rtl/debug_mode_ctrl.sv
// Purpose: mode and access control for a single-wire background debug port
// Assumes: command decoder and core share clk; wire and alt clock are async
// Notes:   link frames are start bit, eight bits lsb first, stop bit
`timescale 1ns/1ps
`include "debug_mode_defs.svh"
module debug_mode_ctrl
    import debug_mode_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic [1:0] flash_security,
    input  wire logic       reset_por,
    input  wire logic       reset_forced,
    input  wire logic       reset_watchdog,
    input  wire logic       reset_bad_opcode,
    input  wire logic       reset_bad_address,
    input  wire logic       debug_wire_in,
    output logic            debug_wire_out,
    output logic            debug_wire_oe,
    input  wire logic       alt_clk_in,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_byte,
    output logic            tx_ready,
    output logic            rx_valid,
    output logic [7:0]      rx_byte,
    input  wire logic       cmd_valid,
    input  wire cmd_class_t cmd_class,
    input  wire logic [1:0] cmd_byte_sel,
    input  wire logic       cmd_byte_write,
    input  wire logic [7:0] cmd_byte_wdata,
    output logic            cmd_accept,
    output logic            cmd_reject,
    output logic [7:0]      byte_rdata,
    output logic            mass_erase_request,
    output logic            step_request,
    output logic            forced_reset_request,
    input  wire logic       core_stop_enter,
    input  wire logic       core_wake,
    input  wire logic       halt_instr,
    input  wire logic       bkpt_halt,
    input  wire logic       illegal_reset_disable,
    output logic            core_halted,
    output logic            fetch_enable,
    output logic            wake_request,
    output logic            illegal_reset,
    output logic            illegal_exception,
    output logic            secure,
    output logic            debug_port_enable,
    output logic            debug_clock_select,
    output logic            stop_clocks_run,
    output logic            regulator_standby_allow,
    output logic            serial_tick
);
    core_state_t state;
    logic        wire_s1, wire_s2, wire_low;
    logic        alt_s1, alt_s2, alt_s3, alt_edge;
    logic        div_tick;
    logic        in_reset_d, release_now;
    logic        por_c, forced_c, wdog_c, opc_c, addr_c, wire_low_c;
    logic [3:0]  halt_after;
    logic [7:0]  ctrl_three;
    logic        boot_halt, open_en, accept_now;
    logic        tx_busy, tx_oe, rx_busy, sync_busy, sync_drive;
    logic [9:0]  tx_shift;
    logic [3:0]  tx_count, rx_count;
    logic [7:0]  rx_shift;
    logic [1:0]  rx_quiet;
    logic        do_halt_cmd, do_go, do_step, do_erase, do_byte_wr;

    // synchronisers for wire and alternate clock
    always_ff @(posedge clk) begin
        wire_s1 <= debug_wire_in;
        wire_s2 <= wire_s1;
        alt_s1  <= alt_clk_in;
        alt_s2  <= alt_s1;
        alt_s3  <= alt_s2;
    end
    assign wire_low = !wire_s2;
    assign alt_edge = alt_s2 && !alt_s3;

    // serial clock enable
    always_ff @(posedge clk) begin
        if (reset) div_tick <= 1'b0;
        else       div_tick <= !div_tick;
    end
    assign serial_tick = (debug_clock_select ? div_tick : alt_edge)
                         && !(state == CORE_STOP && !debug_port_enable);

    // reset cause capture while reset is held
    always_ff @(posedge clk) begin
        in_reset_d <= reset;
        if (reset) begin
            por_c      <= reset_por;
            forced_c   <= reset_forced;
            wdog_c     <= reset_watchdog;
            opc_c      <= reset_bad_opcode;
            addr_c     <= reset_bad_address;
            wire_low_c <= wire_low;
        end
    end
    assign release_now = in_reset_d && !reset;

    // security sampled at release
    always_ff @(posedge clk) begin
        if (reset)            secure <= 1'b1;
        else if (release_now) secure <= (flash_security != `SEC_OPEN_CODE);
    end

    assign boot_halt = (por_c && wire_low_c) || (forced_c && wire_low_c)
                     || (forced_c && halt_after[`C2_HALT_FORCED_BIT])
                     || (wdog_c && halt_after[`C2_HALT_WDOG_BIT])
                     || (opc_c && halt_after[`C2_HALT_OPC_BIT])
                     || (addr_c && halt_after[`C2_HALT_ADDR_BIT]);

    assign open_en = !secure && debug_port_enable;

    // command acceptance by security, enable and core state
    always_comb begin
        accept_now = 1'b0;
        case (cmd_class)
            CMD_BYTE_ACCESS: accept_now = 1'b1;
            CMD_READ_STATUS,
            CMD_MASS_ERASE:  accept_now = 1'b1;
            CMD_MEM,
            CMD_MEM_STATUS,
            CMD_DREG:        accept_now = open_en && (state != CORE_STOP);
            CMD_ENTER_HALT:  accept_now = open_en;
            CMD_CPU_REG:     accept_now = open_en && (state != CORE_RUN);
            CMD_STEP,
            CMD_GO:          accept_now = open_en && (state == CORE_HALT);
            default:         accept_now = 1'b0;
        endcase
    end

    assign do_halt_cmd = cmd_valid && accept_now && (cmd_class == CMD_ENTER_HALT);
    assign do_go       = cmd_valid && accept_now && (cmd_class == CMD_GO);
    assign do_step     = cmd_valid && accept_now && (cmd_class == CMD_STEP);
    assign do_erase    = cmd_valid && accept_now && (cmd_class == CMD_MASS_ERASE);
    assign do_byte_wr  = cmd_valid && (cmd_class == CMD_BYTE_ACCESS) && cmd_byte_write;

    always_ff @(posedge clk) begin
        if (reset) begin
            cmd_accept         <= 1'b0;
            cmd_reject         <= 1'b0;
            mass_erase_request <= 1'b0;
            step_request       <= 1'b0;
            forced_reset_request <= 1'b0;
        end else begin
            cmd_accept         <= cmd_valid && accept_now;
            cmd_reject         <= cmd_valid && !accept_now;
            mass_erase_request <= do_erase;
            step_request       <= do_step;
            forced_reset_request <= do_byte_wr && cmd_byte_sel == `BSEL_CTRL_TWO
                                    && cmd_byte_wdata[`C2_FORCE_BIT];
        end
    end

    // ext_ctrl_status_reg top byte: enable and clock select
    always_ff @(posedge clk) begin
        if (reset) begin
            debug_port_enable  <= 1'b0;
            debug_clock_select <= 1'b0;
        end else if (release_now) begin
            debug_port_enable  <= boot_halt;
            debug_clock_select <= boot_halt;
        end else if (do_byte_wr && cmd_byte_sel == `BSEL_EXT_CTRL) begin
            debug_port_enable  <= cmd_byte_wdata[`XC_ENABLE_BIT];
            debug_clock_select <= cmd_byte_wdata[`XC_CLKSEL_BIT];
        end
    end

    // ctrl_status_two halt-after bits survive all but power-on reset
    always_ff @(posedge clk) begin
        if (reset && reset_por) begin
            halt_after <= `CTRL_TWO_RESET;
        end else if (!reset && do_byte_wr && cmd_byte_sel == `BSEL_CTRL_TWO) begin
            halt_after <= cmd_byte_wdata[3:0];
        end
    end

    always_ff @(posedge clk) begin
        if (reset)
            ctrl_three <= `CTRL_THREE_RESET;
        else if (do_byte_wr && cmd_byte_sel == `BSEL_CTRL_THREE)
            ctrl_three <= cmd_byte_wdata;
    end

    // top byte read data
    always_ff @(posedge clk) begin
        if (reset) begin
            byte_rdata <= 8'h00;
        end else if (cmd_valid && cmd_class == CMD_BYTE_ACCESS) begin
            case (cmd_byte_sel)
                `BSEL_EXT_CTRL:   byte_rdata <= {debug_port_enable, debug_clock_select, 6'h00};
                `BSEL_CTRL_TWO:   byte_rdata <= {4'h0, halt_after};
                `BSEL_CTRL_THREE: byte_rdata <= ctrl_three;
                default:          byte_rdata <= 8'h00;
            endcase
        end else if (cmd_valid && cmd_class == CMD_READ_STATUS) begin
            byte_rdata <= {7'h00, secure};
        end
    end

    // core mode state
    always_ff @(posedge clk) begin
        if (reset) begin
            state <= CORE_RUN;
        end else if (release_now) begin
            state <= boot_halt ? CORE_HALT : CORE_RUN;
        end else begin
            case (state)
                CORE_RUN: begin
                    if (do_halt_cmd) state <= CORE_HALT;
                    else if ((halt_instr || bkpt_halt) && debug_port_enable)
                        state <= CORE_HALT;
                    else if (core_stop_enter) state <= CORE_STOP;
                end
                CORE_STOP: begin
                    if (do_halt_cmd)    state <= CORE_HALT;
                    else if (core_wake) state <= CORE_RUN;
                end
                CORE_HALT: begin
                    if (do_go) state <= CORE_RUN;
                end
                default: state <= CORE_RUN;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            wake_request      <= 1'b0;
            illegal_reset     <= 1'b0;
            illegal_exception <= 1'b0;
        end else begin
            wake_request      <= do_halt_cmd && state == CORE_STOP;
            illegal_reset     <= halt_instr && !debug_port_enable
                                 && !illegal_reset_disable;
            illegal_exception <= halt_instr && !debug_port_enable && illegal_reset_disable;
        end
    end

    assign core_halted             = (state == CORE_HALT);
    assign fetch_enable            = (state == CORE_RUN);
    assign stop_clocks_run         = debug_port_enable;
    assign regulator_standby_allow = !debug_port_enable;

    // transmit: start, eight bits, stop; low bits pull the wire
    assign tx_ready = !tx_busy && !rx_busy && !sync_busy;

    always_ff @(posedge clk) begin
        if (reset) begin
            tx_busy  <= 1'b0;
            tx_oe    <= 1'b0;
            tx_shift <= 10'h3FF;
            tx_count <= 4'h0;
        end else if (tx_valid && tx_ready) begin
            tx_shift <= {1'b1, tx_byte, 1'b0};
            tx_count <= `TX_FRAME_BITS;
            tx_busy  <= 1'b1;
        end else if (tx_busy && serial_tick) begin
            if (tx_count == 4'h0) begin
                tx_busy <= 1'b0;
                tx_oe   <= 1'b0;
            end else begin
                tx_oe    <= !tx_shift[0];
                tx_shift <= {1'b1, tx_shift[9:1]};
                tx_count <= tx_count - 4'h1;
            end
        end
    end

    // receive: start low, eight bits, stop must read high
    always_ff @(posedge clk) begin
        if (reset) begin
            rx_busy  <= 1'b0;
            rx_count <= 4'h0;
            rx_shift <= 8'h00;
            rx_byte  <= 8'h00;
            rx_valid <= 1'b0;
            rx_quiet <= 2'h3;
        end else begin
            rx_valid <= 1'b0;
            // stale synchroniser lows after own drive or reset are no start bit
            rx_quiet <= (tx_oe || sync_drive) ? 2'h3 : {1'b0, rx_quiet[1]};
            if (serial_tick) begin
                if (!rx_busy) begin
                    if (wire_low && !tx_busy && !sync_busy && rx_quiet == 2'h0) begin
                        rx_busy  <= 1'b1;
                        rx_count <= `RX_FRAME_BITS;
                    end
                end else if (rx_count == 4'h1) begin
                    rx_busy <= 1'b0;
                    if (!wire_low) begin
                        rx_byte  <= rx_shift;
                        rx_valid <= 1'b1;
                    end
                end else begin
                    rx_shift <= {!wire_low, rx_shift[7:1]};
                    rx_count <= rx_count - 4'h1;
                end
            end
        end
    end

    sync_responder #(
        .REQ_TICKS  (`SYNC_REQ_TICKS),
        .RESP_TICKS (`SYNC_RESP_TICKS)
    ) u_sync (
        .clk      (clk),
        .reset    (reset),
        .tick     (serial_tick),
        .wire_low (wire_low),
        .busy     (sync_busy),
        .drive    (sync_drive)
    );

    assign debug_wire_out = 1'b0;
    assign debug_wire_oe  = tx_oe || sync_drive;

    sequence s_release_boot;
        release_now && boot_halt;
    endsequence

    a_secure_blocks_mem: assert property (@(posedge clk) disable iff (reset)
        (cmd_valid && secure && cmd_class == CMD_MEM) |=> (cmd_reject && !cmd_accept))
        else $error("memory command accepted on secured part");
    a_disabled_blocks_dreg: assert property (@(posedge clk) disable iff (reset)
        (cmd_valid && !debug_port_enable && cmd_class == CMD_DREG) |=> cmd_reject)
        else $error("register command accepted with port disabled");
    a_byte_always_ok: assert property (@(posedge clk) disable iff (reset)
        (cmd_valid && cmd_class == CMD_BYTE_ACCESS) |=> cmd_accept)
        else $error("top byte access refused");
    a_mem_not_in_stop: assert property (@(posedge clk) disable iff (reset)
        (cmd_valid && state == CORE_STOP && cmd_class == CMD_MEM_STATUS) |=> cmd_reject)
        else $error("memory command accepted in stop");
    a_step_needs_halt: assert property (@(posedge clk) disable iff (reset)
        (cmd_valid && state != CORE_HALT && cmd_class == CMD_STEP) |=> !step_request)
        else $error("step issued while not halted");
    a_boot_halt_state: assert property (@(posedge clk) disable iff (reset)
        s_release_boot |=> (core_halted && debug_port_enable && debug_clock_select))
        else $error("boot to halt did not halt with enable and select set");
    a_reset_clears_en: assert property (@(posedge clk) disable iff (reset)
        (release_now && !boot_halt) |=> !debug_port_enable)
        else $error("enable set after plain reset");
    a_halt_cmd_wakes: assert property (@(posedge clk) disable iff (reset)
        (do_halt_cmd && state == CORE_STOP) |=> (core_halted && wake_request) ##1 !wake_request)
        else $error("enter halt from stop missed wake or halt");
    a_illegal_halt: assert property (@(posedge clk) disable iff (reset)
        (halt_instr && !debug_port_enable) |=> (illegal_reset != illegal_exception)
                                               && !$changed(state))
        else $error("disabled halt instruction not treated as illegal");
    a_half_clock: assert property (@(posedge clk) disable iff (reset)
        (debug_clock_select && serial_tick) |=> !serial_tick)
        else $error("half clock tick not every second cycle");
    a_halt_no_fetch: assert property (@(posedge clk) disable iff (reset)
        (state == CORE_RUN && bkpt_halt && debug_port_enable) |=> !fetch_enable)
        else $error("fetch continued after breakpoint halt");

endmodule : debug_mode_ctrl

//--- tb/debug_host_model.sv
// Purpose: host debug tool on the single wire
// Assumes: wire has a pull-up, paced by the serial tick
// Notes:   sends and receives start, eight bits lsb first, stop
`timescale 1ns/1ps
module debug_host_model (
    input  wire logic       clk,
    input  wire logic       tick,
    input  wire logic       wire_lvl,
    input  wire logic       hold_low,
    input  wire logic       send,
    input  wire logic [7:0] send_byte,
    output logic            host_oe,
    output logic [7:0]      got_byte,
    output logic            got_v
);
    logic [3:0] tcnt = 4'h0;
    logic [3:0] rcnt = 4'h0;
    logic [9:0] sh   = 10'h3FF;
    // byte frames both ways on one wire
    always @(posedge clk) begin
        got_v <= 1'b0;
        if (tick && tcnt != 4'h0) begin
            sh   <= {1'b1, sh[9:1]};
            tcnt <= tcnt - 4'h1;
        end else if (tick && send) begin
            sh   <= {1'b1, send_byte, 1'b0};
            tcnt <= 4'hA;
        end
        if (tick && rcnt == 4'h0 && !wire_lvl && !host_oe) begin
            rcnt <= 4'h1;
        end else if (tick && rcnt != 4'h0) begin
            got_byte <= {wire_lvl, got_byte[7:1]};
            rcnt     <= (rcnt == 4'h8) ? 4'h0 : rcnt + 4'h1;
            got_v    <= (rcnt == 4'h8);
        end
    end
    // long low is the sync request; released wire floats high
    assign host_oe = hold_low || (tcnt != 4'h0 && !sh[0]);
endmodule : debug_host_model

//--- tb/single_wire_debug_mode_control_bench.sv
// Purpose: bench for debug mode control
// Assumes: open-drain wire with pull-up
// Notes:   command answers checked from a queue
`timescale 1ns/1ps
`include "debug_mode_defs.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fail_count++; \
    $display("mismatch at %0t: %0h vs %0h", $time, g, e); end end
module single_wire_debug_mode_control_bench
    import debug_mode_pkg::*;
;
logic clk = 1'b0, reset = 1'b1, alt_clk_in = 1'b0, reset_por = 1'b0, reset_forced = 1'b0;
logic reset_watchdog = 1'b0, reset_bad_opcode = 1'b0, reset_bad_address = 1'b0;
logic tx_valid = 1'b0, cmd_valid = 1'b0, cmd_byte_write = 1'b0, core_stop_enter = 1'b0;
logic core_wake = 1'b0, halt_instr = 1'b0, bkpt_halt = 1'b0, illegal_reset_disable = 1'b0;
logic hold = 1'b0, send = 1'b0;
logic [1:0] flash_security = `SEC_OPEN_CODE, cmd_byte_sel = 2'h0;
logic [7:0] tx_byte = 8'h00, cmd_byte_wdata = 8'h00, sbyte = 8'h00, d;
cmd_class_t cmd_class = CMD_BYTE_ACCESS;
logic debug_wire_oe, tx_ready, rx_valid, cmd_accept, cmd_reject, mass_erase_request;
logic step_request, forced_reset_request, core_halted, fetch_enable, wake_request;
logic illegal_reset, illegal_exception, secure, debug_port_enable, debug_clock_select;
logic stop_clocks_run, regulator_standby_allow, serial_tick, host_oe, got_v, wire_lvl;
logic [7:0] rx_byte, byte_rdata, got;
int fail_count = 0, check_count = 0, cycles = 0, n;
integer seed = 32'hb88b;
logic exp_q[$];
assign wire_lvl = !(host_oe || debug_wire_oe);
debug_mode_ctrl DUT (.clk, .reset, .flash_security, .reset_por, .reset_forced,
    .reset_watchdog, .reset_bad_opcode, .reset_bad_address, .debug_wire_in(wire_lvl),
    .debug_wire_out(), .debug_wire_oe, .alt_clk_in, .tx_valid, .tx_byte, .tx_ready,
    .rx_valid, .rx_byte, .cmd_valid, .cmd_class, .cmd_byte_sel, .cmd_byte_write,
    .cmd_byte_wdata, .cmd_accept, .cmd_reject, .byte_rdata, .mass_erase_request,
    .step_request, .forced_reset_request, .core_stop_enter, .core_wake, .halt_instr,
    .bkpt_halt, .illegal_reset_disable, .core_halted, .fetch_enable, .wake_request,
    .illegal_reset, .illegal_exception, .secure, .debug_port_enable, .debug_clock_select,
    .stop_clocks_run, .regulator_standby_allow, .serial_tick);
debug_host_model host (.clk, .tick(serial_tick), .wire_lvl, .hold_low(hold), .send,
    .send_byte(sbyte), .host_oe, .got_byte(got), .got_v);
initial begin
    forever #20 clk = ~clk;
end
initial begin
    forever #71 alt_clk_in = ~alt_clk_in;
end
task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
        $display("Result: passed");
    else
        $display("Result: failed");
    $finish;
endtask : complete_run
task automatic cmd(input cmd_class_t c, input logic [1:0] s, input logic w,
                   input logic [7:0] v, input logic a);
    @(posedge clk);
    cmd_valid      <= 1'b1;
    cmd_class      <= c;
    cmd_byte_sel   <= s;
    cmd_byte_write <= w;
    cmd_byte_wdata <= v;
    exp_q.push_back(a);
    @(posedge clk);
    cmd_valid <= 1'b0;
    #1;
endtask : cmd
task automatic pulse(input logic [3:0] v);
    @(posedge clk);
    {core_stop_enter, core_wake, halt_instr, bkpt_halt} <= v;
    @(posedge clk);
    {core_stop_enter, core_wake, halt_instr, bkpt_halt} <= 4'h0;
    #1;
endtask : pulse
task automatic do_reset(input logic [4:0] c, input logic low);
    @(posedge clk);
    reset <= 1'b1;
    {reset_por, reset_forced, reset_watchdog, reset_bad_opcode, reset_bad_address} <= c;
    hold <= low;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    {reset_por, reset_forced, reset_watchdog, reset_bad_opcode, reset_bad_address} <= 5'h00;
    hold <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
endtask : do_reset
// answer monitor and hang limit
always @(posedge clk) begin
    cycles++;
    if (cmd_accept || cmd_reject) begin
        `CHK({cmd_accept, cmd_reject}, {exp_q[0], !exp_q[0]})
        exp_q.delete(0);
    end
    if (cycles > 20000) begin
        fail_count++;
        complete_run();
    end
end
initial begin
    do_reset(5'h10, 1'b0);
    `CHK({debug_port_enable, secure, regulator_standby_allow}, 3'b001)
    cmd(CMD_MEM, 2'h0, 1'b0, 8'h00, 1'b0);
    cmd(CMD_DREG, 2'h0, 1'b0, 8'h00, 1'b0);
    pulse(4'h2);
    `CHK({illegal_reset, illegal_exception, core_halted}, 3'b100)
    @(posedge clk) illegal_reset_disable <= 1'b1;
    pulse(4'h2);
    `CHK({illegal_reset, illegal_exception}, 2'b01)
    $display("disabled port test done");
    cmd(CMD_BYTE_ACCESS, `BSEL_EXT_CTRL, 1'b1, 8'hC0, 1'b1);
    `CHK({debug_clock_select, stop_clocks_run, regulator_standby_allow}, 3'b110)
    n = 0;
    repeat (20) begin
        @(posedge clk);
        #1;
        n += serial_tick;
    end
    `CHK(n, 10)
    d = $random(seed);
    cmd(CMD_BYTE_ACCESS, `BSEL_CTRL_THREE, 1'b1, d, 1'b1);
    cmd(CMD_BYTE_ACCESS, `BSEL_CTRL_THREE, 1'b0, 8'h00, 1'b1);
    `CHK(byte_rdata, d)
    for (int k = 3; k < 10; k++)
        if (k != 6) cmd(cmd_class_t'(k), 2'h0, 1'b0, 8'h00, k < 6);
    pulse(4'h1);
    `CHK({core_halted, fetch_enable}, 2'b10)
    for (int k = 3; k < 9; k++)
        cmd(cmd_class_t'(k), 2'h0, 1'b0, 8'h00, 1'b1);
    `CHK(step_request, 1'b1)
    cmd(CMD_GO, 2'h0, 1'b0, 8'h00, 1'b1);
    `CHK({core_halted, fetch_enable}, 2'b01)
    pulse(4'h2);
    `CHK(core_halted, 1'b1)
    cmd(CMD_GO, 2'h0, 1'b0, 8'h00, 1'b1);
    pulse(4'h8);
    cmd(CMD_MEM, 2'h0, 1'b0, 8'h00, 1'b0);
    cmd(CMD_MEM_STATUS, 2'h0, 1'b0, 8'h00, 1'b0);
    cmd(CMD_CPU_REG, 2'h0, 1'b0, 8'h00, 1'b1);
    cmd(CMD_ENTER_HALT, 2'h0, 1'b0, 8'h00, 1'b1);
    `CHK({wake_request, core_halted}, 2'b11)
    $display("core state test done");
    cmd(CMD_BYTE_ACCESS, `BSEL_CTRL_TWO, 1'b1, 8'h84, 1'b1);
    `CHK(forced_reset_request, 1'b1)
    cmd(CMD_BYTE_ACCESS, `BSEL_CTRL_TWO, 1'b0, 8'h00, 1'b1);
    `CHK(byte_rdata, 8'h04)
    do_reset(5'h04, 1'b0);
    `CHK({core_halted, debug_port_enable}, 2'b11)
    do_reset(5'h10, 1'b1);
    `CHK({core_halted, debug_port_enable, debug_clock_select}, 3'b111)
    $display("boot halt test done");
    d = $random(seed);
    @(posedge clk);
    tx_valid <= 1'b1;
    tx_byte  <= d;
    do @(posedge clk); while (!tx_ready);
    tx_valid <= 1'b0;
    n = 0;
    do begin
        @(posedge clk);
        #1;
        n++;
    end while (!got_v && n < 200);
    `CHK(got, d)
    d = $random(seed);
    repeat (4) @(posedge clk);
    sbyte <= d;
    send  <= 1'b1;
    repeat (3) @(posedge clk);
    send <= 1'b0;
    n = 0;
    do begin
        @(posedge clk);
        #1;
        n++;
    end while (!rx_valid && n < 200);
    `CHK(rx_byte, d)
    repeat (10) @(posedge clk);
    hold <= 1'b1;
    repeat (40) @(posedge clk);
    hold <= 1'b0;
    n = 0;
    repeat (150) begin
        @(posedge clk);
        #1;
        n += debug_wire_oe;
    end
    `CHK(n, 2 * `SYNC_RESP_TICKS)
    $display("link test done");
    @(posedge clk) flash_security <= 2'h0;
    do_reset(5'h00, 1'b0);
    cmd(CMD_BYTE_ACCESS, `BSEL_EXT_CTRL, 1'b1, 8'h80, 1'b1);
    cmd(CMD_MEM, 2'h0, 1'b0, 8'h00, 1'b0);
    cmd(CMD_READ_STATUS, 2'h0, 1'b0, 8'h00, 1'b1);
    `CHK(byte_rdata, 8'h01)
    cmd(CMD_MASS_ERASE, 2'h0, 1'b0, 8'h00, 1'b1);
    `CHK(mass_erase_request, 1'b1)
    $display("secure test done");
    repeat (3) @(posedge clk);
    complete_run();
end
endmodule : single_wire_debug_mode_control_bench
